// file: tmg_gateway.sv
// Thread message gateway: channel open/close table, forwarded writes, acknowledgements
`timescale 1ns/10ps
`default_nettype none
`include "tmg_regs.svh"

module tmg_gateway #(
	parameter int NUM_THREADS = 16,
	parameter int DATA_W = 32,
	parameter int OFF_W = 8,
	parameter bit LEGACY_NOTIFY = 1'b0
) (
	input wire logic clk, // 100 MHz clock
	input wire logic nrst, // Synchronous reset, active low
	input wire logic reqValid, // Request message offered
	output logic reqReady, // Gateway takes the request
	input wire logic [$clog2(NUM_THREADS)-1:0] reqThread, // Requester thread id
	input wire logic [`TMG_DESC_W-1:0] reqDesc, // Message descriptor
	input wire logic [$clog2(NUM_THREADS)-1:0] reqRecipient, // Recipient thread id
	input wire logic [OFF_W-1:0] reqOffset, // Register offset in recipient
	input wire logic [OFF_W-1:0] reqPostDest, // Requester post destination
	input wire logic [DATA_W-1:0] reqData, // Payload to be written
	output logic wbValid, // Writeback message offered
	input wire logic wbReady, // Register file takes the writeback
	output logic wbAck, // Writeback is an acknowledgement
	output logic [$clog2(NUM_THREADS)-1:0] wbThread, // Thread whose file is written
	output logic [OFF_W-1:0] wbOffset, // Register offset written
	output logic [DATA_W-1:0] wbData, // Data written
	output logic notifyZero, // Pulse: bump counter zero of notifyThread
	output logic notifyTwo, // Pulse: bump counter two of notifyThread
	output logic [$clog2(NUM_THREADS)-1:0] notifyThread // Thread to notify
);
	localparam int TID_W = $clog2(NUM_THREADS);

	// Refuse shapes the decode cannot serve
	generate
		if (NUM_THREADS < 2 || DATA_W < 2 || OFF_W < 1) begin : g_badParam
			$error("tmg_gateway: unsupported parameter values");
		end
	endgenerate

	tmg_pkg::tmg_state_e state_r, state_nxt;
	logic [NUM_THREADS-1:0] chanOpen_r, chanOpen_nxt;
	logic ackPend_r, ackPend_nxt;
	logic [TID_W-1:0] ackThread_r, ackThread_nxt;
	logic [OFF_W-1:0] ackDest_r, ackDest_nxt;
	tmg_pkg::tmg_notify_t notifySel_r, notifySel_nxt;
	logic wbAck_r, wbAck_nxt;
	logic [TID_W-1:0] wbThread_r, wbThread_nxt;
	logic [OFF_W-1:0] wbOffset_r, wbOffset_nxt;
	logic [DATA_W-1:0] wbData_r, wbData_nxt;
	logic notifyZero_r, notifyZero_nxt;
	logic notifyTwo_r, notifyTwo_nxt;
	logic [TID_W-1:0] notifyThread_r, notifyThread_nxt;

	// Descriptor decode; reserved bits 13:3 are not looked at
	tmg_pkg::tmg_sub_t reqSub;
	tmg_pkg::tmg_notify_t reqNotify;
	logic reqAck;
	logic reqFire;
	logic wbFire;
	assign reqSub = reqDesc[`TMG_SUB_MSB:`TMG_SUB_LSB];
	assign reqAck = reqDesc[`TMG_ACK_BIT];
	// Earlier variant carries only the low bit, mapped to counter zero
	assign reqNotify = LEGACY_NOTIFY ? {1'b0, reqDesc[`TMG_NOTIFY_LSB]} :
		reqDesc[`TMG_NOTIFY_MSB:`TMG_NOTIFY_LSB];
	assign reqFire = reqValid && reqReady;
	assign wbFire = wbValid && wbReady;

	// One request at a time; a stalled writeback holds off the next request
	assign reqReady = (state_r == tmg_pkg::ST_IDLE);
	assign wbValid = (state_r != tmg_pkg::ST_IDLE);
	assign wbAck = wbAck_r;
	assign wbThread = wbThread_r;
	assign wbOffset = wbOffset_r;
	assign wbData = wbData_r;
	assign notifyZero = notifyZero_r;
	assign notifyTwo = notifyTwo_r;
	assign notifyThread = notifyThread_r;

	// Next state of the gateway sequencer and channel table
	always_comb begin
		state_nxt = state_r;
		chanOpen_nxt = chanOpen_r;
		ackPend_nxt = ackPend_r;
		ackThread_nxt = ackThread_r;
		ackDest_nxt = ackDest_r;
		notifySel_nxt = notifySel_r;
		wbAck_nxt = wbAck_r;
		wbThread_nxt = wbThread_r;
		wbOffset_nxt = wbOffset_r;
		wbData_nxt = wbData_r;
		notifyZero_nxt = 1'b0;
		notifyTwo_nxt = 1'b0;
		notifyThread_nxt = notifyThread_r;
		unique case (state_r)
			tmg_pkg::ST_IDLE: begin
				if (reqFire) begin
					// Thread ids are global, so the execution unit never matters
					ackPend_nxt = reqAck;
					ackThread_nxt = reqThread;
					ackDest_nxt = reqPostDest;
					notifySel_nxt = `TMG_NOTIFY_NONE;
					// Ack flag only rises when an acknowledgement will really follow
					wbAck_nxt = reqAck;
					wbThread_nxt = reqThread;
					wbOffset_nxt = reqPostDest;
					wbData_nxt = {{(DATA_W-2){1'b0}}, `TMG_ERR_OK};
					state_nxt = reqAck ? tmg_pkg::ST_ACK : tmg_pkg::ST_IDLE;
					if (reqSub == `TMG_SUB_OPEN) begin
						chanOpen_nxt[reqThread] = 1'b1;
					end else if (reqSub == `TMG_SUB_CLOSE) begin
						chanOpen_nxt[reqThread] = 1'b0;
					end else if (reqSub == `TMG_SUB_FORWARD) begin
						if (chanOpen_r[reqRecipient]) begin
							// Deliver the payload first, acknowledge afterwards
							notifySel_nxt = reqNotify;
							wbAck_nxt = 1'b0;
							wbThread_nxt = reqRecipient;
							wbOffset_nxt = reqOffset;
							wbData_nxt = reqData;
							state_nxt = tmg_pkg::ST_FWD;
						end else begin
							// Closed recipient: write is dropped
							wbData_nxt = {{(DATA_W-2){1'b0}}, `TMG_ERR_CLOSED};
						end
					end else begin
						// No read or other service here, only an error answer
						wbData_nxt = {{(DATA_W-2){1'b0}}, `TMG_ERR_BADFUNC};
					end
				end
			end
			tmg_pkg::ST_FWD: begin
				if (wbFire) begin
					// Notify only once the data has landed; reserved code bumps nothing
					notifyZero_nxt = (notifySel_r == `TMG_NOTIFY_ZERO);
					notifyTwo_nxt = (notifySel_r == `TMG_NOTIFY_TWO);
					notifyThread_nxt = wbThread_r;
					wbAck_nxt = ackPend_r;
					wbThread_nxt = ackThread_r;
					wbOffset_nxt = ackDest_r;
					wbData_nxt = {{(DATA_W-2){1'b0}}, `TMG_ERR_OK};
					state_nxt = ackPend_r ? tmg_pkg::ST_ACK : tmg_pkg::ST_IDLE;
				end
			end
			tmg_pkg::ST_ACK: begin
				if (wbFire) begin
					wbAck_nxt = 1'b0;
					ackPend_nxt = 1'b0;
					state_nxt = tmg_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// Register everything; all channels start closed
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_r <= tmg_pkg::ST_IDLE;
			chanOpen_r <= '0;
			ackPend_r <= 1'b0;
			ackThread_r <= '0;
			ackDest_r <= '0;
			notifySel_r <= `TMG_NOTIFY_NONE;
			wbAck_r <= 1'b0;
			wbThread_r <= '0;
			wbOffset_r <= '0;
			wbData_r <= '0;
			notifyZero_r <= 1'b0;
			notifyTwo_r <= 1'b0;
			notifyThread_r <= '0;
		end else begin
			state_r <= state_nxt;
			chanOpen_r <= chanOpen_nxt;
			ackPend_r <= ackPend_nxt;
			ackThread_r <= ackThread_nxt;
			ackDest_r <= ackDest_nxt;
			notifySel_r <= notifySel_nxt;
			wbAck_r <= wbAck_nxt;
			wbThread_r <= wbThread_nxt;
			wbOffset_r <= wbOffset_nxt;
			wbData_r <= wbData_nxt;
			notifyZero_r <= notifyZero_nxt;
			notifyTwo_r <= notifyTwo_nxt;
			notifyThread_r <= notifyThread_nxt;
		end
	end

	// Checks on the gateway behaviour
	sequence s_fwdDone;
		wbFire && !wbAck;
	endsequence

	property p_openAccepts;
		@(posedge clk) disable iff (!nrst)
		reqFire && reqSub == `TMG_SUB_OPEN |=> chanOpen_r[$past(reqThread)];
	endproperty
	a_openAccepts: assert property (p_openAccepts) else $error("open did not set channel");

	property p_closeBlocks;
		@(posedge clk) disable iff (!nrst)
		reqFire && reqSub == `TMG_SUB_FORWARD && !chanOpen_r[reqRecipient] |=>
			state_r != tmg_pkg::ST_FWD;
	endproperty
	a_closeBlocks: assert property (p_closeBlocks) else $error("write reached closed thread");

	property p_forwardDelivers;
		@(posedge clk) disable iff (!nrst)
		reqFire && reqSub == `TMG_SUB_FORWARD && chanOpen_r[reqRecipient] |=>
			wbValid && !wbAck && wbThread == $past(reqRecipient) && wbData == $past(reqData);
	endproperty
	a_forwardDelivers: assert property (p_forwardDelivers) else $error("forward misdelivered");

	property p_wbHolds;
		@(posedge clk) disable iff (!nrst)
		wbValid && !wbReady |=> wbValid && $stable(wbData) && $stable(wbThread);
	endproperty
	a_wbHolds: assert property (p_wbHolds) else $error("writeback dropped before taken");

	property p_notifyZero;
		@(posedge clk) disable iff (!nrst)
		s_fwdDone ##0 (notifySel_r == `TMG_NOTIFY_ZERO) |=> notifyZero && !notifyTwo;
	endproperty
	a_notifyZero: assert property (p_notifyZero) else $error("counter zero not bumped");

	property p_notifyReserved;
		@(posedge clk) disable iff (!nrst)
		s_fwdDone ##0 (notifySel_r == 2'h3) |=> !notifyZero && !notifyTwo;
	endproperty
	a_notifyReserved: assert property (p_notifyReserved) else $error("reserved notify acted");

	property p_notifyOnlyForward;
		@(posedge clk) disable iff (!nrst)
		(notifyZero || notifyTwo) |-> $past(state_r == tmg_pkg::ST_FWD && wbReady);
	endproperty
	a_notifyOnlyForward: assert property (p_notifyOnlyForward) else $error("notify off forward");

	property p_noAckWhenClear;
		@(posedge clk) disable iff (!nrst)
		reqFire && !reqAck |=> (!wbAck)[*2];
	endproperty
	a_noAckWhenClear: assert property (p_noAckWhenClear) else $error("unrequested ack");

	property p_badFuncError;
		@(posedge clk) disable iff (!nrst)
		reqFire && reqAck && reqSub > `TMG_SUB_FORWARD |=>
			wbAck && wbThread == $past(reqThread) && wbData == {{(DATA_W-2){1'b0}}, `TMG_ERR_BADFUNC};
	endproperty
	a_badFuncError: assert property (p_badFuncError) else $error("unsupported code not refused");
endmodule
`default_nettype wire

// file: tmg_regs.svh
// Descriptor field positions, encodings and answer codes for the thread message gateway
`ifndef TMG_REGS_SVH
`define TMG_REGS_SVH

`define TMG_DESC_W 17
`define TMG_SUB_MSB 2
`define TMG_SUB_LSB 0
`define TMG_ACK_BIT 14
`define TMG_NOTIFY_MSB 16
`define TMG_NOTIFY_LSB 15

`define TMG_SUB_OPEN 3'h0
`define TMG_SUB_CLOSE 3'h1
`define TMG_SUB_FORWARD 3'h2

`define TMG_NOTIFY_NONE 2'h0
`define TMG_NOTIFY_ZERO 2'h1
`define TMG_NOTIFY_TWO 2'h2

`define TMG_ERR_OK 2'h0
`define TMG_ERR_CLOSED 2'h1
`define TMG_ERR_BADFUNC 2'h2

`endif

// file: tmg_pkg.sv
// Types shared by the thread message gateway
package tmg_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_FWD, ST_ACK} tmg_state_e;
	typedef logic [2:0] tmg_sub_t;
	typedef logic [1:0] tmg_notify_t;
	typedef logic [1:0] tmg_err_t;
endpackage

// file: tmg_rf_model.sv
// Register file side model: takes writebacks, optionally stalls, logs each one
`timescale 1ns/10ps
`default_nettype none

module tmg_rf_model (
	input wire logic clk, // Clock
	input wire logic nrst, // Synchronous reset, active low
	input wire logic slow, // Stall most cycles when high
	input wire logic wbValid, // Writeback offered
	output logic wbReady, // Writeback taken
	input wire logic wbAck, // Acknowledgement flag
	input wire logic [3:0] wbThread, // Target thread
	input wire logic [7:0] wbOffset, // Register offset
	input wire logic [31:0] wbData // Data word
);
	logic [1:0] stallCnt_r;
	logic [44:0] log[$];

	// Slow mode takes one cycle in four, so a stalled writeback must be held
	assign wbReady = !slow || (stallCnt_r == 2'h3);

	// Log every taken writeback; the bench compares them in order
	always @(posedge clk) begin
		stallCnt_r <= nrst ? stallCnt_r + 2'h1 : 2'h0;
		if (nrst && wbValid && wbReady) begin
			log.push_back({wbAck, wbThread, wbOffset, wbData});
		end
	end
endmodule

`default_nettype wire

// file: tmg_tb.sv
// Self-checking bench for the thread message gateway
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic clk = 1'b0, nrst = 1'b0, slow = 1'b0, reqValid = 1'b0, reqReady, wbValid, wbReady;
	logic wbAck, notifyZero, notifyTwo;
	logic [3:0] reqThread = 4'h0, reqRecipient = 4'h0, wbThread, notifyThread;
	logic [16:0] reqDesc = 17'h00000;
	logic [7:0] reqOffset = 8'h10, reqPostDest = 8'h20, wbOffset;
	logic [31:0] reqData = 32'h00000000, wbData;
	int mismatches = 0, checks_done = 0, cycles = 0, zeroCnt = 0, twoCnt = 0;

	tmg_gateway tmg_gateway_i (.clk(clk), .nrst(nrst), .reqValid(reqValid), .reqReady(reqReady),
		.reqThread(reqThread), .reqDesc(reqDesc), .reqRecipient(reqRecipient),
		.reqOffset(reqOffset), .reqPostDest(reqPostDest), .reqData(reqData),
		.wbValid(wbValid), .wbReady(wbReady), .wbAck(wbAck), .wbThread(wbThread),
		.wbOffset(wbOffset), .wbData(wbData), .notifyZero(notifyZero),
		.notifyTwo(notifyTwo), .notifyThread(notifyThread));
	tmg_rf_model tmg_rf_model_i (.clk(clk), .nrst(nrst), .slow(slow), .wbValid(wbValid),
		.wbReady(wbReady), .wbAck(wbAck), .wbThread(wbThread), .wbOffset(wbOffset),
		.wbData(wbData));

	initial begin
		forever #5 clk = ~clk;
	end

	// Notify pulses last one cycle, so count them at every edge
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (notifyZero === 1'b1 && notifyThread === 4'h5) zeroCnt <= zeroCnt + 1;
		if (notifyTwo === 1'b1 && notifyThread === 4'h5) twoCnt <= twoCnt + 1;
		if (cycles == 3000) begin
			mismatches++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string what, input logic [44:0] exp, input logic [44:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask

	// Pop the next logged writeback; an empty log yields unknowns and fails
	task automatic wbq(input logic [44:0] exp);
		logic [44:0] g;
		g = {45{1'bx}};
		if (tmg_rf_model_i.log.size() > 0) g = tmg_rf_model_i.log.pop_front();
		chk("writeback", exp, g);
	endtask

	// Offer one request, hold it until taken, then wait for the gateway to idle
	task automatic send(input logic [3:0] thr, input logic [2:0] sub, input logic ack,
		input logic [1:0] ntf, input logic [3:0] rcp, input logic [31:0] dat);
		int n;
		reqThread = thr;
		reqDesc = {ntf, ack, 11'h000, sub};
		reqRecipient = rcp;
		reqData = dat;
		reqValid = 1'b1; // Remote writes only through the request port
		for (n = 0; n < 20 && reqReady !== 1'b1; n++) @(posedge clk) #1;
		@(posedge clk) #1;
		reqValid = 1'b0;
		for (n = 0; n < 40 && !(reqReady === 1'b1 && wbValid === 1'b0); n++) @(posedge clk) #1;
		@(posedge clk) #1;
	endtask

	task automatic t_closed();
		send(4'h3, 3'h2, 1'b1, 2'h1, 4'h5, 32'h11111111);
		wbq({1'b1, 4'h3, 8'h20, 32'h00000001});
		chk("log empty", 45'h0, 45'(tmg_rf_model_i.log.size()));
		chk("notify zero", 45'h0, 45'(zeroCnt));
		$display("test closed recipient done");
	endtask

	task automatic t_open_fwd();
		send(4'h5, 3'h0, 1'b0, 2'h0, 4'h0, 32'h0);
		chk("open silent", 45'h0, 45'(tmg_rf_model_i.log.size()));
		send(4'h3, 3'h2, 1'b1, 2'h1, 4'h5, 32'hA5A5C3C3);
		wbq({1'b0, 4'h5, 8'h10, 32'hA5A5C3C3});
		wbq({1'b1, 4'h3, 8'h20, 32'h00000000});
		chk("notify zero", 45'h1, 45'(zeroCnt));
		$display("test open and forward done");
	endtask

	task automatic t_notify();
		slow = 1'b1;
		send(4'h5, 3'h2, 1'b0, 2'h2, 4'h5, 32'h0F0F0F0F);
		wbq({1'b0, 4'h5, 8'h10, 32'h0F0F0F0F});
		chk("notify two", 45'h1, 45'(twoCnt));
		send(4'h6, 3'h2, 1'b0, 2'h3, 4'h5, 32'h12345678);
		wbq({1'b0, 4'h5, 8'h10, 32'h12345678});
		chk("reserved notify", 45'h2, 45'(zeroCnt + twoCnt));
		slow = 1'b0;
		$display("test notify select done");
	endtask

	task automatic t_close();
		send(4'h5, 3'h1, 1'b1, 2'h0, 4'h0, 32'h0);
		wbq({1'b1, 4'h5, 8'h20, 32'h00000000});
		send(4'h3, 3'h2, 1'b1, 2'h1, 4'h5, 32'h99999999);
		wbq({1'b1, 4'h3, 8'h20, 32'h00000001});
		chk("log empty", 45'h0, 45'(tmg_rf_model_i.log.size()));
		$display("test close done");
	endtask

	task automatic t_badsub();
		logic [2:0] s;
		for (s = 3'h3; s != 3'h0; s++) begin
			send(4'h3, s, 1'b1, 2'h1, 4'h5, 32'hFFFFFFFF);
			wbq({1'b1, 4'h3, 8'h20, 32'h00000002});
		end
		chk("notify ignored", 45'h1, 45'(zeroCnt));
		$display("test unsupported subfunctions done");
	endtask

	initial begin
		repeat (8) @(posedge clk);
		#1 nrst = 1'b1;
		@(posedge clk) #1;
		t_closed();
		t_open_fwd();
		t_notify();
		t_close();
		t_badsub();
		give_verdict();
	end
endmodule

`default_nettype wire
